// file: hdl/fft_defines.svh
// Constants for the fall-through FIFO slice controller.
`ifndef FFT_DEFINES_SVH
`define FFT_DEFINES_SVH
`define FFT_WORD_W 4
`define FFT_BUF_DEPTH 16
`define FFT_BITS_PER_WORD 4
`define FFT_SLICE_DEPTH 64
`define FFT_STROBE_NS 800
`define FFT_CLK_NS 100
`define FFT_STROBE_CYC ((`FFT_STROBE_NS + `FFT_CLK_NS - 1) / `FFT_CLK_NS)
`define FFT_MODE_PAR 1'b0
`define FFT_MODE_SER 1'b1
`endif

// file: hdl/fft_pkg.sv
// Types for the fall-through FIFO slice controller.
package fft_pkg;
  typedef enum logic [2:0] {
    FFT_IDLE = 3'b000,
    FFT_LOAD = 3'b001,
    FFT_PUSH = 3'b010,
    FFT_CLKH = 3'b011,
    FFT_CLKL = 3'b100,
    FFT_WAIT = 3'b101
  } fft_wr_e;
  typedef enum logic [2:0] {
    FFT_RIDLE = 3'b000,
    FFT_RREQ = 3'b001,
    FFT_RTAKE = 3'b010,
    FFT_RSHH = 3'b011,
    FFT_RSHL = 3'b100,
    FFT_RDROP = 3'b101
  } fft_rd_e;
  typedef struct packed {
    logic parallel_load;
    logic serial_in_clk_n;
    logic serial_in_enable_n;
    logic push_to_stack_n;
    logic serial_in_bit;
    logic [3:0] par_in_bits;
  } fft_wr_pins_s;
  typedef struct packed {
    logic parallel_unload_strobe;
    logic serial_unload_req_n;
    logic serial_out_enable_n;
    logic serial_out_clk_n;
    logic out_enable_n;
  } fft_rd_pins_s;
endpackage

// file: hdl/fft_buf.sv
// Parameterised word FIFO with combinational read data.
`timescale 1ns/100ps
module fft_buf #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic do_wr;
  logic do_rd;
  assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_q != '0);
  assign do_wr = clk_en_in && wr_valid_in && wr_ready_out;
  assign do_rd = clk_en_in && rd_ready_in && rd_valid_out;
  always_comb begin
    rd_data_out = mem_q[rp_q];
  end
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// file: hdl/fft_host.sv
// Host controller that feeds and drains one fall-through FIFO slice through its pins.
// Contract
// - Hold serial input clock low during load.
// - Hold parallel load low in serial entry.
// - Hold output clock low while loading.
// - Full ties push; valid ties request.
// - Chaining adds 63 words per slice.
// - Wide arrays share push and request.
`timescale 1ns/100ps
`include "fft_defines.svh"
module fft_host (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic wr_mode_in,
  input wire logic rd_mode_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [3:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [3:0] rd_data_out,
  input wire logic in_reg_full_n_in,
  input wire logic output_reg_valid_in,
  input wire logic serial_out_bit_in,
  input wire logic [3:0] par_out_bits_in,
  output logic master_reset_n_out,
  output fft_pkg::fft_wr_pins_s wr_pins_out,
  output fft_pkg::fft_rd_pins_s rd_pins_out
);
  localparam logic [3:0] STROBE_CYC = 4'(`FFT_STROBE_CYC);
  fft_pkg::fft_wr_e wst_q;
  fft_pkg::fft_rd_e rst_q;
  logic [1:0] full_sync_q;
  logic [1:0] valid_sync_q;
  logic [1:0] sbit_sync_q;
  logic [3:0] pout_s1_q;
  logic [3:0] pout_s2_q;
  logic [3:0] wcnt_q;
  logic [3:0] rcnt_q;
  logic [1:0] wbit_q;
  logic [1:0] rbit_q;
  logic [3:0] wword_q;
  logic [3:0] rword_q;
  logic rvalid_q;
  logic rst_done_q;
  logic buf_ready;
  logic buf_valid;
  logic [3:0] buf_data;
  logic buf_take;
  logic buf_push;
  logic full_n;
  logic dev_valid;
  assign full_n = full_sync_q[1];
  assign dev_valid = valid_sync_q[1];
  // Words leave only while the slice shows room, so any chained depth behind it works unchanged.
  assign buf_take = clk_en_in && (wst_q == fft_pkg::FFT_IDLE) && buf_valid && rst_done_q && full_n;
  // The buffer accepts only words the user saw accepted, so a held valid is never written twice.
  assign buf_push = wr_valid_in && wr_ready_out;

  // Write data passes through the buffer so a stalled slice back-pressures the source.
  fft_buf #(.WIDTH(`FFT_WORD_W), .DEPTH(`FFT_BUF_DEPTH)) u_buf (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .wr_valid_in(buf_push),
    .wr_ready_out(buf_ready),
    .wr_data_in(wr_data_in),
    .rd_valid_out(buf_valid),
    .rd_ready_in(buf_take),
    .rd_data_out(buf_data)
  );

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      // The full flag idles high, so its synchroniser starts there as well.
      full_sync_q <= 2'h3;
      valid_sync_q <= 2'h0;
      sbit_sync_q <= 2'h0;
      pout_s1_q <= 4'h0;
      pout_s2_q <= 4'h0;
    end else if (clk_en_in) begin
      full_sync_q <= {full_sync_q[0], in_reg_full_n_in};
      valid_sync_q <= {valid_sync_q[0], output_reg_valid_in};
      sbit_sync_q <= {sbit_sync_q[0], serial_out_bit_in};
      pout_s1_q <= par_out_bits_in;
      pout_s2_q <= pout_s1_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ready_out <= 1'b0;
    end else if (clk_en_in) begin
      wr_ready_out <= buf_ready && !(wr_valid_in && wr_ready_out);
    end
  end

  // Master reset is pulsed low for one strobe width after system reset.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      master_reset_n_out <= 1'b0;
      rst_done_q <= 1'b0;
    end else if (clk_en_in) begin
      if (!rst_done_q && wcnt_q == STROBE_CYC) begin
        master_reset_n_out <= 1'b1;
        rst_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wst_q <= fft_pkg::FFT_IDLE;
      wcnt_q <= 4'h0;
      wbit_q <= 2'h0;
      wword_q <= 4'h0;
      wr_pins_out <= '{parallel_load: 1'b0, serial_in_clk_n: 1'b0, serial_in_enable_n: 1'b0,
                       push_to_stack_n: 1'b1, serial_in_bit: 1'b0, par_in_bits: 4'h0};
    end else if (clk_en_in) begin
      if (!rst_done_q) begin
        wcnt_q <= (wcnt_q == STROBE_CYC) ? 4'h0 : wcnt_q + 4'h1;
      end else begin
        case (wst_q)
          fft_pkg::FFT_IDLE: begin
            // A word left in the input register by a full stack keeps its push request standing.
            wr_pins_out.push_to_stack_n <= full_n;
            if (buf_take) begin
              wword_q <= buf_data;
              wcnt_q <= 4'h0;
              wbit_q <= 2'h0;
              if (wr_mode_in == `FFT_MODE_PAR) begin
                wr_pins_out.serial_in_clk_n <= 1'b0;
                wr_pins_out.par_in_bits <= buf_data;
                wr_pins_out.parallel_load <= 1'b1;
                wst_q <= fft_pkg::FFT_LOAD;
              end else begin
                wr_pins_out.parallel_load <= 1'b0;
                wr_pins_out.serial_in_bit <= buf_data[0];
                wr_pins_out.serial_in_clk_n <= 1'b1;
                wst_q <= fft_pkg::FFT_CLKH;
              end
            end
          end
          fft_pkg::FFT_LOAD: begin
            wcnt_q <= wcnt_q + 4'h1;
            if (wcnt_q == STROBE_CYC) begin
              wr_pins_out.parallel_load <= 1'b0;
              wcnt_q <= 4'h0;
              wst_q <= fft_pkg::FFT_PUSH;
            end
          end
          fft_pkg::FFT_CLKH: begin
            wcnt_q <= wcnt_q + 4'h1;
            if (wcnt_q == STROBE_CYC) begin
              wr_pins_out.serial_in_clk_n <= 1'b0;
              wcnt_q <= 4'h0;
              wst_q <= fft_pkg::FFT_CLKL;
            end
          end
          fft_pkg::FFT_CLKL: begin
            wcnt_q <= wcnt_q + 4'h1;
            if (wcnt_q == STROBE_CYC) begin
              wcnt_q <= 4'h0;
              if (wbit_q == 2'h3) begin
                wst_q <= fft_pkg::FFT_PUSH;
              end else begin
                wbit_q <= wbit_q + 2'h1;
                wr_pins_out.serial_in_bit <= wword_q[2'(wbit_q + 2'h1)];
                wr_pins_out.serial_in_clk_n <= 1'b1;
                wst_q <= fft_pkg::FFT_CLKH;
              end
            end
          end
          fft_pkg::FFT_PUSH: begin
            wcnt_q <= wcnt_q + 4'h1;
            if (wcnt_q == STROBE_CYC) begin
              wr_pins_out.push_to_stack_n <= 1'b0;
              wcnt_q <= 4'h0;
              wst_q <= fft_pkg::FFT_WAIT;
            end
          end
          fft_pkg::FFT_WAIT: begin
            wcnt_q <= wcnt_q + 4'h1;
            if (wcnt_q == STROBE_CYC) begin
              wcnt_q <= 4'h0;
              wst_q <= fft_pkg::FFT_IDLE;
            end
          end
          default: begin
            wst_q <= fft_pkg::FFT_IDLE;
          end
        endcase
      end
    end
  end

  // Read side: request a word, then take it in parallel or shift it out serially.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rst_q <= fft_pkg::FFT_RIDLE;
      rcnt_q <= 4'h0;
      rbit_q <= 2'h0;
      rword_q <= 4'h0;
      rvalid_q <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 4'h0;
      rd_pins_out <= '{parallel_unload_strobe: 1'b0, serial_unload_req_n: 1'b1,
                       serial_out_enable_n: 1'b0, serial_out_clk_n: 1'b0, out_enable_n: 1'b0};
    end else if (clk_en_in) begin
      if (rd_valid_out && rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end else if (rvalid_q && !rd_valid_out) begin
        rd_valid_out <= 1'b1;
        rd_data_out <= rword_q;
        rvalid_q <= 1'b0;
      end
      case (rst_q)
        fft_pkg::FFT_RIDLE: begin
          rd_pins_out.serial_out_clk_n <= 1'b0;
          if (rst_done_q && !rvalid_q) begin
            rd_pins_out.parallel_unload_strobe <= 1'b1;
            rd_pins_out.serial_unload_req_n <= 1'b0;
            rcnt_q <= 4'h0;
            rst_q <= fft_pkg::FFT_RREQ;
          end
        end
        fft_pkg::FFT_RREQ: begin
          if (dev_valid) begin
            rcnt_q <= 4'h0;
            rbit_q <= 2'h0;
            rd_pins_out.serial_unload_req_n <= 1'b1;
            rst_q <= (rd_mode_in == `FFT_MODE_PAR) ? fft_pkg::FFT_RTAKE : fft_pkg::FFT_RSHH;
          end
        end
        fft_pkg::FFT_RTAKE: begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == STROBE_CYC) begin
            rword_q <= pout_s2_q;
            rvalid_q <= 1'b1;
            rd_pins_out.parallel_unload_strobe <= 1'b0;
            rcnt_q <= 4'h0;
            rst_q <= fft_pkg::FFT_RDROP;
          end
        end
        fft_pkg::FFT_RSHH: begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == STROBE_CYC) begin
            rword_q[rbit_q] <= sbit_sync_q[1];
            rd_pins_out.serial_out_clk_n <= 1'b1;
            rcnt_q <= 4'h0;
            rst_q <= fft_pkg::FFT_RSHL;
          end
        end
        fft_pkg::FFT_RSHL: begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == STROBE_CYC) begin
            rd_pins_out.serial_out_clk_n <= 1'b0;
            rcnt_q <= 4'h0;
            if (rbit_q == 2'h3) begin
              rvalid_q <= 1'b1;
              rd_pins_out.parallel_unload_strobe <= 1'b0;
              rst_q <= fft_pkg::FFT_RDROP;
            end else begin
              rbit_q <= rbit_q + 2'h1;
              rst_q <= fft_pkg::FFT_RSHH;
            end
          end
        end
        fft_pkg::FFT_RDROP: begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == STROBE_CYC && !dev_valid) begin
            rcnt_q <= 4'h0;
            rst_q <= fft_pkg::FFT_RIDLE;
          end
        end
        default: begin
          rst_q <= fft_pkg::FFT_RIDLE;
        end
      endcase
    end
  end
endmodule

// file: tb/fft_host_checker.sv
// Concurrent checks on the pin and stream ports of the slice host controller.
`timescale 1ns/100ps
module fft_host_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic master_reset_n_out,
  input wire fft_pkg::fft_wr_pins_s wr_pins_out,
  input wire fft_pkg::fft_rd_pins_s rd_pins_out,
  input wire logic rd_valid_out,
  input wire logic rd_ready_in,
  input wire logic [3:0] rd_data_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_load_clk_low: assert property (
    wr_pins_out.parallel_load |-> !wr_pins_out.serial_in_clk_n) else $error("serial clock high during load");
  a_serial_no_load: assert property (
    $rose(wr_pins_out.serial_in_clk_n) |-> (!wr_pins_out.parallel_load) [*8]) else $error("load during serial entry");
  a_load_hold: assert property (
    $rose(wr_pins_out.parallel_load) |-> wr_pins_out.parallel_load [*8]) else $error("load pulse too short");
  a_push_hold: assert property (
    $fell(wr_pins_out.push_to_stack_n) |-> (!wr_pins_out.push_to_stack_n) [*8]) else $error("push pulse too short");
  a_push_no_load: assert property (
    !wr_pins_out.push_to_stack_n |-> !wr_pins_out.parallel_load) else $error("push while loading");
  a_unload_clk_low: assert property (
    $rose(rd_pins_out.parallel_unload_strobe) |-> !rd_pins_out.serial_out_clk_n) else $error("out clock high at load");
  a_strobe_request: assert property (
    $rose(rd_pins_out.parallel_unload_strobe) |-> !rd_pins_out.serial_unload_req_n) else $error("strobe without request");
  a_out_clk_pulse: assert property (
    $rose(rd_pins_out.serial_out_clk_n) |-> rd_pins_out.serial_out_clk_n [*8] ##[1:3] !rd_pins_out.serial_out_clk_n)
    else $error("bad serial out pulse");
  a_mr_release: assert property (
    $fell(sys_rst_in) |-> (!master_reset_n_out) [*8] ##[1:12] master_reset_n_out) else $error("bad device reset pulse");
  a_read_hold: assert property (
    rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_data_out)) else $error("read word not held");
endmodule

// file: tb/fft_dev_model.sv
// Behavioural model of one fall-through FIFO slice as seen at its pins.
`timescale 1ns/100ps
module fft_dev_model #(
  parameter int STACK_WORDS = 62
) (
  input wire logic master_reset_n_in,
  input wire fft_pkg::fft_wr_pins_s wr_pins_in,
  input wire fft_pkg::fft_rd_pins_s rd_pins_in,
  output logic in_reg_full_n_out,
  output logic output_reg_valid_out,
  output logic serial_out_bit_out,
  output logic [3:0] par_out_bits_out
);
  logic [3:0] in_bits = 4'h8;
  logic [3:0] out_bits = 4'h0;
  logic full_bit = 1'b0;
  logic req_init = 1'b0;
  logic armed = 1'b0;
  logic ser_en = 1'b0;
  logic [3:0] stack_q[$];
  int shifts = 0;
  initial output_reg_valid_out = 1'b0;
  assign in_reg_full_n_out = ~full_bit;
  // Released outputs show the inverse so a stale value never matches.
  assign par_out_bits_out = rd_pins_in.out_enable_n ? ~out_bits : out_bits;
  assign serial_out_bit_out = ser_en ? out_bits[0] : ~out_bits[0];
  always @(negedge wr_pins_in.serial_in_clk_n) begin
    if (!wr_pins_in.serial_in_enable_n && !full_bit) begin
      {in_bits, full_bit} = {wr_pins_in.serial_in_bit, in_bits};
    end
  end
  always @(negedge rd_pins_in.serial_out_clk_n) begin
    if (ser_en) begin
      out_bits = {1'b0, out_bits[3:1]};
      shifts++;
      if (shifts == 4) begin
        ser_en = 1'b0;
        output_reg_valid_out = 1'b0;
      end
    end
  end
  always #10 begin
    if (!master_reset_n_in) begin
      stack_q.delete();
      in_bits = 4'h8;
      full_bit = 1'b0;
      req_init = 1'b0;
      ser_en = 1'b0;
      output_reg_valid_out = 1'b0;
    end else begin
      if (wr_pins_in.parallel_load) {in_bits, full_bit} = {wr_pins_in.par_in_bits, 1'b1};
      if (!wr_pins_in.push_to_stack_n && full_bit && !req_init && stack_q.size() < STACK_WORDS) begin
        stack_q.push_back(in_bits);
        req_init = 1'b1;
      end
      if (req_init && !wr_pins_in.parallel_load) begin
        in_bits = 4'h8;
        full_bit = 1'b0;
        req_init = 1'b0;
      end
      if (!rd_pins_in.parallel_unload_strobe) begin
        armed = 1'b1;
        output_reg_valid_out = 1'b0;
      end else if (armed && !rd_pins_in.serial_unload_req_n && stack_q.size() > 0) begin
        out_bits = stack_q.pop_front();
        armed = 1'b0;
        ser_en = 1'b1;
        shifts = 0;
        output_reg_valid_out = 1'b1;
      end
    end
  end
endmodule

// file: tb/fft_host_bench.sv
// Self-checking bench for the slice host controller against a slice model.
`timescale 1ns/100ps
module fft_host_bench;
  logic clk_in, sys_rst_in, wr_mode_in, rd_mode_in, wr_valid_in, wr_ready_out, rd_valid_out, rd_ready_in;
  logic [3:0] wr_data_in, rd_data_out, par_out_bits;
  logic in_reg_full_n, output_reg_valid, serial_out_bit, master_reset_n, stalled, clk_en_in;
  fft_pkg::fft_wr_pins_s wr_pins;
  fft_pkg::fft_rd_pins_s rd_pins;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  fft_host uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .wr_mode_in(wr_mode_in),
    .rd_mode_in(rd_mode_in), .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out), .wr_data_in(wr_data_in),
    .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in), .rd_data_out(rd_data_out),
    .in_reg_full_n_in(in_reg_full_n), .output_reg_valid_in(output_reg_valid), .serial_out_bit_in(serial_out_bit),
    .par_out_bits_in(par_out_bits), .master_reset_n_out(master_reset_n), .wr_pins_out(wr_pins),
    .rd_pins_out(rd_pins));
  fft_dev_model dev (.master_reset_n_in(master_reset_n), .wr_pins_in(wr_pins), .rd_pins_in(rd_pins),
    .in_reg_full_n_out(in_reg_full_n), .output_reg_valid_out(output_reg_valid),
    .serial_out_bit_out(serial_out_bit), .par_out_bits_out(par_out_bits));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  task check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task do_reset;
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (25) @(negedge clk_in);
    check({3'h0, output_reg_valid}, 4'h0);
    check({3'h0, in_reg_full_n}, 4'h1);
    check({3'h0, master_reset_n}, 4'h1);
  endtask
  task send(input logic [3:0] w);
    wr_data_in = w;
    wr_valid_in = 1'b1;
    while (wr_ready_out !== 1'b1) begin
      stalled = 1'b1;
      @(negedge clk_in);
    end
    @(negedge clk_in);
    wr_valid_in = 1'b0;
    @(negedge clk_in);
  endtask
  task recv(input logic [3:0] e);
    rd_ready_in = 1'b1;
    while (rd_valid_out !== 1'b1) @(negedge clk_in);
    check(rd_data_out, e);
    @(negedge clk_in);
    rd_ready_in = 1'b0;
    @(negedge clk_in);
  endtask
  // Reader stalls while the host buffer fills up and refuses, a clock-enable pause follows,
  // then all words drain in order.
  task t_fill;
    stalled = 1'b0;
    for (int i = 0; i < 20; i++) send(4'(i * 5 + 3));
    check({3'h0, stalled}, 4'h1);
    clk_en_in = 1'b0;
    repeat (30) @(negedge clk_in);
    clk_en_in = 1'b1;
    for (int i = 0; i < 20; i++) recv(4'(i * 5 + 3));
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      wr_mode_in = m[0];
      rd_mode_in = m[1];
      for (int i = 0; i < 3; i++) send(4'(m * 4 + i * 7 + 1));
      for (int i = 0; i < 3; i++) recv(4'(m * 4 + i * 7 + 1));
    end
  endtask
  initial begin
    sys_rst_in = 1'b1;
    clk_en_in = 1'b1;
    wr_mode_in = 1'b0;
    rd_mode_in = 1'b0;
    wr_valid_in = 1'b0;
    rd_ready_in = 1'b0;
    wr_data_in = 4'h0;
    do_reset();
    t_fill();
    do_reset();
    t_modes();
    results();
  end
endmodule
bind fft_host fft_host_checker chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .master_reset_n_out(master_reset_n_out),
  .wr_pins_out(wr_pins_out), .rd_pins_out(rd_pins_out), .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
  .rd_data_out(rd_data_out));
